// ===== accum_move_multiply_negate_exec_test.sv
// Purpose: self-checking bench for the move, multiply and negate group
// Assumes: results and phase 4 strobes stand after the third edge
// Notes: the accumulator is preset through the outside write port
`timescale 1ns/1ps
`default_nettype none
module accum_move_multiply_negate_exec_test;

    // ************************************************************
    // signals and rows
    // ************************************************************
    typedef struct packed {
        logic [15:0] ins;
        logic        vld;
        logic        ld;
        logic [7:0]  ldat;
        logic [7:0]  rdat;
        logic [1:0]  rd;
        logic        wr;
        logic [7:0]  wdat;
        logic        pc;
        logic [7:0]  acc;
        logic [15:0] prod;
        logic [7:0]  st;
    } row_t;

    localparam logic [7:0] NEG_ST = (8'h01 << exec_pkg::FLAG_C)
                                  | (8'h01 << exec_pkg::FLAG_DC)
                                  | (8'h01 << exec_pkg::FLAG_Z);

    logic        core_clk_in    = 1'b0;
    logic        srst_in        = 1'b1;
    logic [15:0] instr_in       = 16'h0000;
    logic        instr_valid_in = 1'b0;
    logic [7:0]  file_rdata_in  = 8'h00;
    logic        acc_load_in    = 1'b0;
    logic [7:0]  acc_load_data_in = 8'h00;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  acc;
    logic [7:0]  ph;
    logic [7:0]  pl;
    logic [7:0]  st;
    logic        rd;
    logic        wr;
    logic        q4;
    logic        pc;
    int          err_count      = 0;
    int          n_tests        = 0;
    row_t        rows [16];

    always #25 core_clk_in = ~core_clk_in;

    exec_core u_dut (
        .core_clk_in             (core_clk_in),
        .srst_in                 (srst_in),
        .instr_in                (instr_in),
        .instr_valid_in          (instr_valid_in),
        .file_rdata_in           (file_rdata_in),
        .acc_load_in             (acc_load_in),
        .acc_load_data_in        (acc_load_data_in),
        .file_addr_out           (addr),
        .file_rd_out             (rd),
        .file_wdata_out          (wdata),
        .file_wr_out             (wr),
        .working_accumulator_out (acc),
        .product_upper_byte_out  (ph),
        .product_lower_byte_out  (pl),
        .status_out              (st),
        .phase_q4_out            (q4),
        .pc_advance_out          (pc)
    );

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check

    task automatic run(input row_t r, input int id);
        logic saw_rd;
        logic saw_wr;
        logic saw_pc;
        int   n_q4;
        saw_rd = 1'b0;
        saw_wr = 1'b0;
        saw_pc = 1'b0;
        n_q4 = 0;
        instr_in = r.ins;
        instr_valid_in = r.vld;
        file_rdata_in = r.rdat;
        acc_load_in = r.ld;
        acc_load_data_in = r.ldat;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_in);
            #1;
            if (q4 === 1'b1) n_q4++;
            if (pc === 1'b1) saw_pc = 1'b1;
            if (rd === 1'b1) begin
                saw_rd = 1'b1;
                check(addr === r.ins[7:0], "read address");
            end
            if (wr === 1'b1) begin
                saw_wr = 1'b1;
                check(i == 2 && q4 === 1'b1, "write outside phase 4");
                check(wdata === r.wdat, "write data");
                check(addr === r.ins[7:0], "write address");
            end
        end
        check(n_q4 == 1, "phase 4 pulse count");
        if (r.rd != 2'd2) check(saw_rd === r.rd[0], "read strobe");
        check(saw_wr === r.wr, "write strobe");
        check(saw_pc === r.pc, "pc advance");
        check(acc === r.acc, "accumulator");
        check({ph, pl} === r.prod, "product");
        check(st === r.st, "status");
        $display("test %0d done", id);
    endtask : run

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        rows = '{
            '{{exec_pkg::STORE_HI, 8'hff}, 1'b1, 1'b0, 8'h00,
              8'h3c, 2'd1, 1'b1, 8'h00, 1'b1, 8'h00, 16'h0000, 8'h00},
            '{16'hffff, 1'b1, 1'b1, 8'he2,
              8'h00, 2'd0, 1'b0, 8'h00, 1'b1, 8'he2, 16'h0000, 8'h00},
            '{{exec_pkg::MUL_IMM_HI, 8'hc4}, 1'b1, 1'b0, 8'h00,
              8'h77, 2'd0, 1'b0, 8'h00, 1'b1, 8'he2, 16'had08, 8'h00},
            '{{exec_pkg::MUL_FILE_HI, 8'h00}, 1'b1, 1'b0, 8'h00,
              8'hb5, 2'd1, 1'b0, 8'h00, 1'b1, 8'he2, 16'h9fca, 8'h00},
            '{{exec_pkg::MUL_IMM_HI, 8'h00}, 1'b1, 1'b0, 8'h00,
              8'h00, 2'd0, 1'b0, 8'h00, 1'b1, 8'he2, 16'h0000, 8'h00},
            '{{exec_pkg::STORE_HI, 8'h10}, 1'b0, 1'b1, 8'h3a,
              8'h00, 2'd0, 1'b0, 8'h00, 1'b0, 8'h3a, 16'h0000, 8'h00},
            '{{exec_pkg::NEG_HI7, 1'b0, 8'h5a}, 1'b1, 1'b0, 8'h00,
              8'hab, 2'd1, 1'b1, 8'hc6, 1'b1, 8'hc6, 16'h0000, 8'h00},
            '{{exec_pkg::NEG_HI7, 1'b1, 8'h80}, 1'b1, 1'b0, 8'h00,
              8'h12, 2'd1, 1'b1, 8'h3a, 1'b1, 8'hc6, 16'h0000, 8'h00},
            '{16'hffff, 1'b1, 1'b1, 8'h80,
              8'h00, 2'd0, 1'b0, 8'h00, 1'b1, 8'h80, 16'h0000, 8'h00},
            '{{exec_pkg::NEG_HI7, 1'b1, 8'h22}, 1'b1, 1'b0, 8'h00,
              8'h00, 2'd1, 1'b1, 8'h80, 1'b1, 8'h80, 16'h0000, 8'h0a},
            '{{exec_pkg::STORE_HI, 8'h33}, 1'b1, 1'b0, 8'h00,
              8'h00, 2'd1, 1'b1, 8'h80, 1'b1, 8'h80, 16'h0000, 8'h0a},
            '{{exec_pkg::MUL_IMM_HI, 8'h55}, 1'b0, 1'b1, 8'h00,
              8'h00, 2'd0, 1'b0, 8'h00, 1'b0, 8'h00, 16'h0000, 8'h0a},
            '{{exec_pkg::NEG_HI7, 1'b0, 8'h01}, 1'b1, 1'b0, 8'h00,
              8'h00, 2'd1, 1'b1, 8'h00, 1'b1, 8'h00, 16'h0000, NEG_ST},
            '{{exec_pkg::MUL_FILE_HI, 8'hff}, 1'b1, 1'b0, 8'h00,
              8'hff, 2'd1, 1'b0, 8'h00, 1'b1, 8'h00, 16'h0000, NEG_ST},
            '{16'hffff, 1'b1, 1'b1, 8'h5c,
              8'h00, 2'd0, 1'b0, 8'h00, 1'b1, 8'h5c, 16'h0000, NEG_ST},
            '{exec_pkg::NOP_WORD, 1'b1, 1'b0, 8'h00,
              8'h00, 2'd0, 1'b0, 8'h00, 1'b1, 8'h5c, 16'h0000, NEG_ST}
        };
        repeat (10) @(posedge core_clk_in);
        #1;
        check(acc === 8'h00 && st === 8'h00 && wr === 1'b0, "reset");
        $display("test reset done");
        srst_in = 1'b0;
        for (int i = 0; i < 16; i++) begin
            run(rows[i], i);
        end
        // reset in the middle of a negate must cancel its write
        instr_in = {exec_pkg::NEG_HI7, 1'b0, 8'h11};
        instr_valid_in = 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1;
        srst_in = 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1;
        check({st, acc, wr} === 17'h00000, "reset mid-run");
        $display("test mid-run reset done");
        srst_in = 1'b0;
        run(rows[0], 16);
        complete_run();
    end

endmodule : accum_move_multiply_negate_exec_test
`default_nettype wire

// ===== exec_core.sv
// Purpose: decode and execute store, multiply, negate and no-operation
// Assumes: instruction word held stable across the four phases
// Notes: file data enters from memory and leaves as a write strobe
`timescale 1ns/1ps
`default_nettype none
module exec_core (
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic [15:0] instr_in,
    input  wire logic        instr_valid_in,
    input  wire logic [7:0]  file_rdata_in,
    input  wire logic        acc_load_in,
    input  wire logic [7:0]  acc_load_data_in,
    output logic      [7:0]  file_addr_out,
    output logic             file_rd_out,
    output logic      [7:0]  file_wdata_out,
    output logic             file_wr_out,
    output logic      [7:0]  working_accumulator_out,
    output logic      [7:0]  product_upper_byte_out,
    output logic      [7:0]  product_lower_byte_out,
    output logic      [7:0]  status_out,
    output logic             phase_q4_out,
    output logic             pc_advance_out
);
    typedef enum logic [4:0] {
        OP_NONE  = 5'h01,
        OP_STORE = 5'h02,
        OP_MULI  = 5'h04,
        OP_MULF  = 5'h08,
        OP_NEG   = 5'h10
    } op_t;

    // ************************************************************
    // decode
    // ************************************************************
    function automatic op_t decode(input logic [15:0] w);
        op_t r;
        r = OP_NONE;
        if (w[15:8] == exec_pkg::STORE_HI) begin // RL1
            r = OP_STORE;
        end else if (w[15:8] == exec_pkg::MUL_IMM_HI) begin // RL2
            r = OP_MULI;
        end else if (w[15:8] == exec_pkg::MUL_FILE_HI) begin // RL3
            r = OP_MULF;
        end else if (w[15:9] == exec_pkg::NEG_HI7) begin // RL9
            r = OP_NEG;
        end
        return r;
    endfunction : decode

    exec_pkg::phase_t phase_q;
    op_t              op_q;
    logic [7:0]       operand_q;
    logic [7:0]       acc_q;
    logic [7:0]       prod_hi_q;
    logic [7:0]       prod_lo_q;
    logic [7:0]       status_q;
    logic [7:0]       addr_q;
    logic             rd_q;
    logic             wr_q;
    logic [7:0]       wdata_q;
    logic             q4_q;
    logic             adv_q;
    logic [15:0]      product;
    logic [7:0]       neg_res;
    logic             neg_c;
    logic             neg_dc;
    logic             neg_ov;
    logic             neg_z;

    negate_unit #(.WIDTH(8)) u_neg (
        .acc_in         (acc_q),
        .result_out     (neg_res),
        .carry_out      (neg_c),
        .half_carry_out (neg_dc),
        .range_out      (neg_ov),
        .zero_out       (neg_z)
    );

    assign product = {8'h00, acc_q} * {8'h00, operand_q}; // RL2

    // ************************************************************
    // four-phase sequencer
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            phase_q <= exec_pkg::PH_Q1;
        end else begin
            case (phase_q)
                exec_pkg::PH_Q1: phase_q <= exec_pkg::PH_Q2;
                exec_pkg::PH_Q2: phase_q <= exec_pkg::PH_Q3;
                exec_pkg::PH_Q3: phase_q <= exec_pkg::PH_Q4;
                exec_pkg::PH_Q4: phase_q <= exec_pkg::PH_Q1; // RL13
                default:         phase_q <= exec_pkg::PH_Q1;
            endcase
        end
    end

    // ************************************************************
    // decode in phase 1, operand read in phase 2
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            op_q      <= OP_NONE;
            addr_q    <= 8'h00;
            rd_q      <= 1'b0;
            operand_q <= 8'h00;
        end else begin
            rd_q <= 1'b0;
            case (phase_q)
                exec_pkg::PH_Q1: begin
                    op_q   <= instr_valid_in ? decode(instr_in) : OP_NONE;
                    addr_q <= instr_in[7:0]; // RL11
                    rd_q   <= instr_valid_in
                              && decode(instr_in) != OP_NONE
                              && decode(instr_in) != OP_MULI; // RL13
                end
                exec_pkg::PH_Q2: begin
                    operand_q <= (op_q == OP_MULI) ? instr_in[7:0]
                                                   : file_rdata_in;
                end
                default: begin
                    operand_q <= operand_q;
                end
            endcase
        end
    end

    // ************************************************************
    // results written in phase 4
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            acc_q     <= exec_pkg::ACC_RST;
            prod_hi_q <= exec_pkg::PROD_RST;
            prod_lo_q <= exec_pkg::PROD_RST;
            status_q  <= exec_pkg::STATUS_RST;
            wr_q      <= 1'b0;
            wdata_q   <= 8'h00;
        end else begin
            wr_q <= 1'b0;
            if (phase_q == exec_pkg::PH_Q3) begin
                case (op_q)
                    OP_STORE: begin
                        wr_q    <= 1'b1; // RL1
                        wdata_q <= acc_q;
                    end
                    OP_MULI, OP_MULF: begin
                        prod_hi_q <= product[15:8]; // RL3
                        prod_lo_q <= product[7:0]; // RL4 RL5
                    end
                    OP_NEG: begin
                        wr_q    <= 1'b1;
                        wdata_q <= neg_res; // RL7 RL8
                        if (!instr_in[exec_pkg::NEG_SEL_BIT]) begin
                            acc_q <= neg_res; // RL7
                        end
                        status_q[exec_pkg::FLAG_C]  <= neg_c; // RL10
                        status_q[exec_pkg::FLAG_DC] <= neg_dc;
                        status_q[exec_pkg::FLAG_Z]  <= neg_z;
                        status_q[exec_pkg::FLAG_OV] <= neg_ov;
                    end
                    default: begin
                        wr_q <= 1'b0; // RL12
                        // accumulator write from instructions outside the group
                        if (acc_load_in) begin
                            acc_q <= acc_load_data_in;
                        end
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // cycle markers
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            q4_q  <= 1'b0;
            adv_q <= 1'b0;
        end else begin
            q4_q  <= (phase_q == exec_pkg::PH_Q3);
            adv_q <= (phase_q == exec_pkg::PH_Q3) && instr_valid_in; // RL12
        end
    end

    assign file_addr_out           = addr_q;
    assign file_rd_out             = rd_q;
    assign file_wdata_out          = wdata_q;
    assign file_wr_out             = wr_q;
    assign working_accumulator_out = acc_q;
    assign product_upper_byte_out  = prod_hi_q;
    assign product_lower_byte_out  = prod_lo_q;
    assign status_out              = status_q;
    assign phase_q4_out            = q4_q;
    assign pc_advance_out          = adv_q;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_mul_q3;
        phase_q == exec_pkg::PH_Q3 && (op_q == OP_MULI || op_q == OP_MULF);
    endsequence

    a_store_writes_acc: assert property (@(posedge core_clk_in) // RL1
        disable iff (srst_in)
        phase_q == exec_pkg::PH_Q3 && op_q == OP_STORE
        |=> file_wr_out && file_wdata_out == $past(acc_q)
            && $stable(status_q))
        else $error("store did not write accumulator");
    a_mul_product: assert property (@(posedge core_clk_in) // RL2
        disable iff (srst_in)
        s_mul_q3 |=> {prod_hi_q, prod_lo_q} == $past(acc_q) * $past(operand_q))
        else $error("product wrong");
    a_mul_keeps_acc: assert property (@(posedge core_clk_in) // RL4
        disable iff (srst_in)
        s_mul_q3 |=> $stable(acc_q) && !file_wr_out)
        else $error("multiply disturbed operands");
    a_mul_no_flags: assert property (@(posedge core_clk_in) // RL5
        disable iff (srst_in)
        s_mul_q3 |=> $stable(status_q))
        else $error("multiply changed flags");
    a_neg_value: assert property (@(posedge core_clk_in) // RL6
        disable iff (srst_in)
        phase_q == exec_pkg::PH_Q3 && op_q == OP_NEG
        |=> file_wr_out && file_wdata_out == 8'(~$past(acc_q) + 8'h01))
        else $error("negate value wrong");
    a_neg_sel_zero: assert property (@(posedge core_clk_in) // RL7
        disable iff (srst_in)
        phase_q == exec_pkg::PH_Q3 && op_q == OP_NEG && !instr_in[8]
        |=> acc_q == file_wdata_out)
        else $error("negate did not update accumulator");
    a_neg_sel_one: assert property (@(posedge core_clk_in) // RL8
        disable iff (srst_in)
        phase_q == exec_pkg::PH_Q3 && op_q == OP_NEG && instr_in[8]
        |=> $stable(acc_q))
        else $error("negate changed accumulator");
    a_neg_zero_flag: assert property (@(posedge core_clk_in) // RL10
        disable iff (srst_in)
        phase_q == exec_pkg::PH_Q3 && op_q == OP_NEG
        |=> status_q[exec_pkg::FLAG_Z] == (file_wdata_out == 8'h00)
            && status_q[7:4] == $past(status_q[7:4]))
        else $error("negate flags wrong");
    a_nop_quiet: assert property (@(posedge core_clk_in) // RL12
        disable iff (srst_in)
        phase_q == exec_pkg::PH_Q3 && op_q == OP_NONE && !acc_load_in
        |=> !file_wr_out && $stable(acc_q) && $stable(status_q))
        else $error("idle cycle changed state");
    a_phase_cycle: assert property (@(posedge core_clk_in) // RL13
        disable iff (srst_in)
        phase_q == exec_pkg::PH_Q1 |=> phase_q == exec_pkg::PH_Q2
        ##1 phase_q == exec_pkg::PH_Q3 ##1 phase_q == exec_pkg::PH_Q4)
        else $error("phase order broken");
endmodule : exec_core
`default_nettype wire

// ===== exec_pkg.sv
// Purpose: constants for the accumulator move, multiply and negate group
// Assumes: 16-bit instruction words, 8-bit data, four phases per cycle
// Notes: nothing is imported; users write exec_pkg::name
// Operation
// RL1 - store copies accumulator to file register, flags untouched, read phase 2, write phase 4
// RL2 - multiply immediate 1011 1100 forms unsigned 16-bit product, high byte upper
// RL3 - multiply file 0011 0100 writes unsigned product of accumulator and register
// RL4 - multiplies keep accumulator and the source register unchanged
// RL5 - multiplies change no status flag, even for a zero product
// RL6 - negate forms inverse of accumulator plus one, eight bits wide
// RL7 - negate with select 0 writes result to accumulator and register
// RL8 - negate with select 1 writes only the register, accumulator kept
// RL9 - negate decoded by upper seven bits 0010 110, bit 8 selects destination
// RL10 - negate updates overflow, carry, half carry and zero; others kept
// RL11 - eight-bit file address reaches all 256 data locations 00h to ffh
// RL12 - all-zero word is a no-operation changing nothing
// RL13 - each instruction is one word, one cycle, read phase 2, write phase 4
package exec_pkg;

    // ************************************************************
    // encodings
    // ************************************************************
    localparam logic [7:0]  STORE_HI    = 8'h01;
    localparam logic [7:0]  MUL_IMM_HI  = 8'hbc;
    localparam logic [7:0]  MUL_FILE_HI = 8'h34;
    localparam logic [6:0]  NEG_HI7     = 7'h16;
    localparam logic [15:0] NOP_WORD    = 16'h0000;
    localparam int          NEG_SEL_BIT = 8;

    // ************************************************************
    // status bit positions and reset values
    // ************************************************************
    localparam int         FLAG_C     = 0;
    localparam int         FLAG_DC    = 1;
    localparam int         FLAG_Z     = 2;
    localparam int         FLAG_OV    = 3;
    localparam logic [7:0] ACC_RST    = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] PROD_RST   = 8'h00;
    localparam int         PHASES     = 4;

    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } phase_t;

endpackage : exec_pkg

// ===== negate_unit.sv
// Purpose: two's complement of the accumulator with its flag outputs
// Assumes: purely combinational, eight bits wide
// Notes: flags follow a subtraction of the accumulator from zero
`timescale 1ns/1ps
`default_nettype none
module negate_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] acc_in,
    output logic      [WIDTH-1:0] result_out,
    output logic                  carry_out,
    output logic                  half_carry_out,
    output logic                  range_out,
    output logic                  zero_out
);
    logic [WIDTH:0] sum;
    logic [4:0]     low_sum;

    // ************************************************************
    // inverse plus one
    // ************************************************************
    assign sum            = {1'b0, ~acc_in} + {{WIDTH{1'b0}}, 1'b1}; // RL6
    assign low_sum        = {1'b0, ~acc_in[3:0]} + 5'h01;
    assign result_out     = sum[WIDTH-1:0];
    assign carry_out      = sum[WIDTH];
    assign half_carry_out = low_sum[4];
    assign range_out      = acc_in[WIDTH-1] & sum[WIDTH-1];
    assign zero_out       = (sum[WIDTH-1:0] == '0);
endmodule : negate_unit
`default_nettype wire
